// ===== rtl/pmc_defines.svh
// register indices, field positions, write masks and the flag2 reset value of the main control registers
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH
// register select codes (data bit 0 is frame bit 8)
`define PMC_IDX_CTRL2      3'h0
`define PMC_IDX_CLOCK      3'h1
`define PMC_IDX_MASK1      3'h2
`define PMC_IDX_MASK2      3'h3
`define PMC_IDX_FLAG1      3'h4
`define PMC_IDX_FLAG2      3'h5
// regulator_config_two fields
`define PMC_LIN_TSD_CFG    9
`define PMC_LS_DRV_LSB     3
`define PMC_HS_DRV_LSB     0
`define PMC_CTRL2_WMASK    16'h161b
// clock_setup fields
`define PMC_SPREAD_RANGE   15
`define PMC_MUX_LSB        11
`define PMC_PHASE_LSB      8
`define PMC_OUT_SRC        7
`define PMC_EXT_SEL        6
`define PMC_EXT_DIV        5
`define PMC_SPREAD_EN      4
`define PMC_CLOCK_WMASK    16'hffbf
// masks, flags
`define PMC_MASK1_WMASK    16'h5616
`define PMC_MASK2_WMASK    16'h075f
`define PMC_FLAG1_STICKY   16'hb616
`define PMC_FLAG2_STICKY   16'hc0f3
`define PMC_FLAG2_RESET    16'h40f1
`define PMC_EXT_DIV_LAST   2'h2
`endif

// ===== rtl/pmc_main_regs.sv
// main-domain control, mask and event flag registers
`timescale 1ns/1ns
`default_nettype none
`include "pmc_defines.svh"
module pmc_main_regs #(
  parameter logic [15:0] CTRL2_RESET = 16'h0000
) (
  // clock, reset, enable
  input  wire logic              clk_in,
  input  wire logic              reset_in,
  input  wire logic              clk_en_in,
  // register access from the serial bus decoder
  input  wire logic [2:0]        reg_sel_in,
  input  wire logic              reg_wr_in,
  input  wire logic [15:0]       reg_wdata_in,
  output logic      [15:0]       reg_rdata_out,
  // analog event levels
  input  wire logic              battery_uvh_in,
  input  wire logic              prereg_overcurrent_in,
  input  wire logic              core_buck_overcurrent_in,
  input  wire logic              aux_buck_overcurrent_in,
  input  wire logic              linear_reg_overcurrent_in,
  input  wire logic              core_buck_thermal_in,
  input  wire logic              aux_buck_thermal_in,
  input  wire logic              linear_reg_thermal_in,
  input  wire logic              prereg_feedback_ov_in,
  input  wire logic              supply_uv7_in,
  input  wire logic              prereg_uvl_in,
  input  wire logic              prereg_uvh_in,
  input  wire logic              supply_uvl_in,
  input  wire logic              supply_uvh_in,
  input  wire logic              wake_in_a_in,
  input  wire logic              wake_in_b_in,
  // live status levels
  input  wire logic              ext_ref_freq_in_window_in,
  input  wire logic              core_buck_on_state_in,
  input  wire logic              aux_buck_on_state_in,
  input  wire logic              linear_reg_on_state_in,
  input  wire logic              comm_error_in,
  // clocks sampled as data
  input  wire logic              internal_clock_a_in,
  input  wire logic              internal_clock_b_in,
  input  wire logic              external_ref_input_in,
  // control outputs
  output logic                   irq_out,
  output logic                   prereg_summary_event_out,
  output logic                   linear_reg_off_req_out,
  output logic                   deep_failsafe_req_out,
  output pmc_pkg::pmc_drive_t    prereg_lowside_drive_out,
  output pmc_pkg::pmc_drive_t    prereg_highside_drive_out,
  output logic                   spread_enable_out,
  output logic                   spread_range_select_out,
  output logic      [3:0]        clock_out_mux_select_out,
  output logic      [3:0]        clock_tune_out,
  output logic                   external_ref_select_request_out,
  output logic                   ext_ref_divided_out,
  output logic                   clock_output_out
);
  import pmc_pkg::*;

  localparam int NSY = 23;

  // two-stage synchronisers for everything off this clock except comm_error_in, which feeds the interrupt unsynchronised
  logic [NSY-1:0] sy1_q, sy1_d, sy_q, sy_d;
  logic [NSY-1:0] raw;
  assign raw = {external_ref_input_in, internal_clock_b_in,
                internal_clock_a_in, linear_reg_on_state_in,
                aux_buck_on_state_in, core_buck_on_state_in,
                ext_ref_freq_in_window_in, wake_in_b_in,
                wake_in_a_in, supply_uvh_in, supply_uvl_in,
                prereg_uvh_in, prereg_uvl_in, supply_uv7_in,
                prereg_feedback_ov_in, linear_reg_thermal_in,
                aux_buck_thermal_in, core_buck_thermal_in,
                linear_reg_overcurrent_in, aux_buck_overcurrent_in,
                core_buck_overcurrent_in, prereg_overcurrent_in,
                battery_uvh_in};

  always_comb
  begin
    sy1_d = clk_en_in ? raw : sy1_q;
    sy_d  = clk_en_in ? sy1_q : sy_q;
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      sy1_q <= '0;
      sy_q  <= '0;
    end
    else
    begin
      sy1_q <= sy1_d;
      sy_q  <= sy_d;
    end
  end

  // register state
  logic [15:0] ctrl2_q, ctrl2_d, clock_q, clock_d;
  logic [15:0] mask1_q, mask1_d, mask2_q, mask2_d;
  logic [15:0] flag1_q, flag1_d, flag2_q, flag2_d;
  logic [15:0] rdata_d;
  logic [2:0]  prev_q, prev_d;
  logic [1:0]  div_cnt_q, div_cnt_d;
  logic        div_tog_q, div_tog_d;
  logic [6:0]  dline_q, dline_d;
  logic        clkout_d, extdiv_d, extsel_d;
  logic        irq_d, summ_d, off_d, deep_d;

  // combinational helpers
  logic [15:0] set1, set2, live1, live2, en1, en2, wr_ones;
  logic        wr1, wr2, src, ref_edge;
  logic [7:0]  taps;

  always_comb
  begin
    wr_ones = reg_wr_in ? reg_wdata_in : 16'h0000;
    wr1 = reg_wr_in && (reg_sel_in == `PMC_IDX_FLAG1);
    wr2 = reg_wr_in && (reg_sel_in == `PMC_IDX_FLAG2);
    // event placement in flag words
    set1 = {sy_q[0], 1'b0, sy_q[1], sy_q[2], 1'b0, sy_q[3], sy_q[4],
            1'b0, 3'h0, sy_q[5], 1'b0, sy_q[6], sy_q[7], 1'b0};
    set2 = {sy_q[8], sy_q[9], 6'h00, sy_q[10], sy_q[11], sy_q[12],
            sy_q[13], 2'h0, sy_q[15] ^ prev_q[1], sy_q[14] ^ prev_q[0]};
    live1 = {8'h00, sy_q[16], 7'h00};
    live2 = {3'h0, sy_q[17], 1'b0, sy_q[18], sy_q[19], 5'h00,
             sy_q[15], sy_q[14], 2'h0};
    // interrupt enables: a clear mask bit lets its flag through
    en1 = ~{mask2_q[10], 1'b0, mask1_q[14], mask1_q[12], 1'b0,
            mask1_q[10], mask1_q[9], 1'b0, 3'h0, mask1_q[4], 1'b0,
            mask1_q[2], mask1_q[1], 1'b0};
    en2 = ~{mask2_q[8], mask2_q[6], 6'h00, mask2_q[4], mask2_q[4],
            mask2_q[3], mask2_q[2], 2'h0, mask2_q[0], mask2_q[1]};
    src = clock_q[`PMC_OUT_SRC] ? sy_q[21] : sy_q[20];
    taps = {dline_q, src};
    ref_edge = sy_q[22] && !prev_q[2];

    ctrl2_d = ctrl2_q;
    clock_d = clock_q;
    mask1_d = mask1_q;
    mask2_d = mask2_q;
    if (reg_wr_in)
    begin
      unique case (reg_sel_in)
        `PMC_IDX_CTRL2: ctrl2_d = reg_wdata_in & `PMC_CTRL2_WMASK;
        `PMC_IDX_CLOCK: clock_d = reg_wdata_in & `PMC_CLOCK_WMASK;
        `PMC_IDX_MASK1: mask1_d = reg_wdata_in & `PMC_MASK1_WMASK;
        `PMC_IDX_MASK2: mask2_d = reg_wdata_in & `PMC_MASK2_WMASK;
        default:        ;
      endcase
    end
    // a set in the same cycle as its clear wins
    flag1_d = ((flag1_q & ~(wr1 ? wr_ones : 16'h0000)) | set1)
              & `PMC_FLAG1_STICKY;
    flag2_d = ((flag2_q & ~(wr2 ? wr_ones : 16'h0000)) | set2)
              & `PMC_FLAG2_STICKY;
    extsel_d = reg_wr_in && (reg_sel_in == `PMC_IDX_CLOCK)
               && reg_wdata_in[`PMC_EXT_SEL];

    rdata_d = 16'h0000;
    unique case (reg_sel_in)
      `PMC_IDX_CTRL2: rdata_d = ctrl2_q;
      `PMC_IDX_CLOCK: rdata_d = clock_q;
      `PMC_IDX_MASK1: rdata_d = mask1_q;
      `PMC_IDX_MASK2: rdata_d = mask2_q;
      `PMC_IDX_FLAG1: rdata_d = flag1_q | live1;
      `PMC_IDX_FLAG2: rdata_d = flag2_q | live2;
      default:        rdata_d = 16'h0000;
    endcase

    irq_d = |(flag1_q & en1) || |(flag2_q & en2)
            || (comm_error_in && !mask2_q[9]);
    summ_d = flag1_q[13] || flag2_q[15] || flag2_q[7]
             || flag2_q[6];
    off_d = sy_q[7];
    deep_d = sy_q[7] && ctrl2_q[`PMC_LIN_TSD_CFG];

    prev_d = {sy_q[22], sy_q[15], sy_q[14]};
    // divide by six: toggle every third rising edge
    div_cnt_d = div_cnt_q;
    div_tog_d = div_tog_q;
    if (ref_edge)
    begin
      if (div_cnt_q == `PMC_EXT_DIV_LAST)
      begin
        div_cnt_d = 2'h0;
        div_tog_d = !div_tog_q;
      end
      else
      begin
        div_cnt_d = div_cnt_q + 2'h1;
      end
    end
    extdiv_d = clock_q[`PMC_EXT_DIV] ? div_tog_q : sy_q[22];
    dline_d = taps[6:0];
    clkout_d = taps[clock_q[`PMC_PHASE_LSB +: 3]];
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      ctrl2_q   <= CTRL2_RESET & `PMC_CTRL2_WMASK;
      clock_q   <= 16'h0000;
      mask1_q   <= 16'h0000;
      mask2_q   <= 16'h0000;
      flag1_q   <= 16'h0000;
      flag2_q   <= `PMC_FLAG2_RESET;
      reg_rdata_out <= 16'h0000;
      prev_q    <= 3'h0;
      div_cnt_q <= 2'h0;
      div_tog_q <= 1'b0;
      dline_q   <= 7'h00;
      clock_output_out <= 1'b0;
      ext_ref_divided_out <= 1'b0;
      external_ref_select_request_out <= 1'b0;
      irq_out   <= 1'b0;
      prereg_summary_event_out <= 1'b0;
      linear_reg_off_req_out <= 1'b0;
      deep_failsafe_req_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      ctrl2_q   <= ctrl2_d;
      clock_q   <= clock_d;
      mask1_q   <= mask1_d;
      mask2_q   <= mask2_d;
      flag1_q   <= flag1_d;
      flag2_q   <= flag2_d;
      reg_rdata_out <= rdata_d;
      prev_q    <= prev_d;
      div_cnt_q <= div_cnt_d;
      div_tog_q <= div_tog_d;
      dline_q   <= dline_d;
      clock_output_out <= clkout_d;
      ext_ref_divided_out <= extdiv_d;
      external_ref_select_request_out <= extsel_d;
      irq_out   <= irq_d;
      prereg_summary_event_out <= summ_d;
      linear_reg_off_req_out <= off_d;
      deep_failsafe_req_out <= deep_d;
    end
  end

  // field outputs straight from register flops
  assign prereg_lowside_drive_out  = pmc_drive_t'(ctrl2_q[`PMC_LS_DRV_LSB +: 2]);
  assign prereg_highside_drive_out = pmc_drive_t'(ctrl2_q[`PMC_HS_DRV_LSB +: 2]);
  assign spread_enable_out         = clock_q[`PMC_SPREAD_EN];
  assign spread_range_select_out   = clock_q[`PMC_SPREAD_RANGE];
  assign clock_out_mux_select_out  = clock_q[`PMC_MUX_LSB +: 4];
  assign clock_tune_out            = clock_q[3:0];

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  flag_set_wins_a: assert property (
    clk_en_in && sy_q[2] && wr1 && reg_wdata_in[12] |=> flag1_q[12])
    else $error("overcurrent flag lost to a same-cycle clear");
  flag_zero_keeps_a: assert property (
    clk_en_in && wr1 && flag1_q[15] && !reg_wdata_in[15] |=> flag1_q[15])
    else $error("flag cleared by writing zero");
  thermal_flag_holds_a: assert property (
    clk_en_in && sy_q[7] ##1 !reset_in && !wr1 |=> flag1_q[1])
    else $error("thermal flag did not stay set");
  irq_unmasked_a: assert property (
    clk_en_in && flag1_q[12] && !mask1_q[12] |=> irq_out)
    else $error("unmasked flag raised no interrupt");
  irq_masked_a: assert property (
    clk_en_in && flag1_q == 16'h0000 && (flag2_q & en2) == 16'h0000 && mask2_q[9] |=> !irq_out)
    else $error("masked events raised an interrupt");
  summary_or_a: assert property (
    clk_en_in && (flag2_q[7] || flag1_q[13]) |=> prereg_summary_event_out)
    else $error("summary bit missed a pre-regulator flag");
  deep_failsafe_state_req_a: assert property (
    clk_en_in && sy_q[7]
    |=> deep_failsafe_req_out == $past(ctrl2_q[`PMC_LIN_TSD_CFG]) && linear_reg_off_req_out)
    else $error("thermal reaction wrong");
  ext_sel_pulse_a: assert property (
    clk_en_in && reg_wr_in && reg_sel_in == `PMC_IDX_CLOCK
    |=> external_ref_select_request_out == $past(reg_wdata_in[`PMC_EXT_SEL]))
    else $error("select request does not follow the write");
  reserved_zero_a: assert property (
    clk_en_in && reg_sel_in == `PMC_IDX_FLAG1
    |=> (reg_rdata_out & ~(`PMC_FLAG1_STICKY | 16'h0080)) == 16'h0000)
    else $error("reserved bit read non-zero");
  live_state_a: assert property (
    clk_en_in && reg_sel_in == `PMC_IDX_FLAG2 |=> reg_rdata_out[12] == $past(sy_q[17]))
    else $error("regulator state not live");
  readback_sel_a: assert property (
    clk_en_in && reg_sel_in == `PMC_IDX_CLOCK |=> reg_rdata_out[`PMC_EXT_SEL] == 1'b0)
    else $error("request bit read back non-zero");
endmodule
`default_nettype wire

// ===== rtl/pmc_pkg.sv
// types shared by the main control register bank
package pmc_pkg;
  typedef enum logic [1:0] {
    PMC_DRIVE_SLOW  = 2'h0,
    PMC_DRIVE_MED   = 2'h1,
    PMC_DRIVE_FAST  = 2'h2,
    PMC_DRIVE_ULTRA = 2'h3
  } pmc_drive_t;
endpackage

// ===== sim/pmc_host_model.sv
// host-side model issuing register accesses to the main control bank
`timescale 1ns/1ns
`default_nettype none
module pmc_host_model (
  // clock
  input  wire logic        clk_in,
  // register access
  input  wire logic [15:0] rdata_in,
  output var  logic [2:0]  sel_out,
  output var  logic        wr_out,
  output var  logic [15:0] wdata_out
);
  initial
  begin
    sel_out = 3'h0;
    wr_out = 1'b0;
    wdata_out = 16'h0;
  end
  // gap models a slow host; idle data inverts so stale data never looks valid
  task automatic write(input logic [2:0] s, input logic [15:0] d, input int gap);
    repeat (gap) @(posedge clk_in);
    @(posedge clk_in);
    sel_out <= s;
    wr_out <= 1'b1;
    wdata_out <= d;
    @(posedge clk_in);
    wr_out <= 1'b0;
    wdata_out <= ~d;
  endtask
  task automatic read(input logic [2:0] s, output logic [15:0] d);
    @(posedge clk_in);
    sel_out <= s;
    @(posedge clk_in);
    #1 d = rdata_in;
  endtask
  // ones only where flags must drop
  task automatic clear(input logic [2:0] s, input logic [15:0] bits);
    write(s, bits, 0);
  endtask
endmodule
`default_nettype wire

// ===== sim/testbench.sv
// self-checking bench for the main control register bank
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import pmc_pkg::*;
  logic        clk_in = 1'b0;
  logic        reset_in = 1'b1;
  logic [15:0] ev = 16'h0;
  logic [2:0]  on_st = 3'h7;
  logic        win = 1'b1;
  logic        comm = 1'b0;
  logic        en = 1'b1;
  logic [2:0]  rck = 3'h0;
  logic [15:0] ha = 16'h0, hb = 16'h0, hc = 16'h0;
  logic [31:0] seed = 32'ha48b8e29;
  logic [31:0] cseed = 32'ha48b8e29;
  logic [15:0] regs [4];
  logic [2:0]  sel;
  logic        wr;
  logic [15:0] wdata, rdata, rd;
  logic        irq, summ, loff, dfs, sen, srng, pulse, rdiv, cout;
  pmc_drive_t  lsd, hsd;
  logic [3:0]  mux, tune;
  int          num_errors = 0;
  int          n_tests = 0;
  localparam logic [15:0] WM [4] = '{16'h161b, 16'hffbf, 16'h5616, 16'h075f};
  localparam int FB [16] = '{15, 13, 12, 10, 9, 4, 2, 1, 15, 14, 7, 6, 5, 4, 0, 1};
  localparam int MB [16] = '{10, 14, 12, 10, 9, 4, 2, 1, 8, 6, 4, 4, 3, 2, 1, 0};
  pmc_host_model u_pmc_host_model (.clk_in(clk_in), .rdata_in(rdata), .sel_out(sel), .wr_out(wr), .wdata_out(wdata));
  pmc_main_regs u_pmc_main_regs (
    .clk_in(clk_in), .reset_in(reset_in), .clk_en_in(en),
    .reg_sel_in(sel), .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .battery_uvh_in(ev[0]), .prereg_overcurrent_in(ev[1]), .core_buck_overcurrent_in(ev[2]),
    .aux_buck_overcurrent_in(ev[3]), .linear_reg_overcurrent_in(ev[4]), .core_buck_thermal_in(ev[5]),
    .aux_buck_thermal_in(ev[6]), .linear_reg_thermal_in(ev[7]), .prereg_feedback_ov_in(ev[8]),
    .supply_uv7_in(ev[9]), .prereg_uvl_in(ev[10]), .prereg_uvh_in(ev[11]), .supply_uvl_in(ev[12]),
    .supply_uvh_in(ev[13]), .wake_in_a_in(ev[14]), .wake_in_b_in(ev[15]),
    .ext_ref_freq_in_window_in(win), .core_buck_on_state_in(on_st[2]), .aux_buck_on_state_in(on_st[1]),
    .linear_reg_on_state_in(on_st[0]), .comm_error_in(comm), .internal_clock_a_in(rck[0]),
    .internal_clock_b_in(rck[1]), .external_ref_input_in(rck[2]), .irq_out(irq),
    .prereg_summary_event_out(summ), .linear_reg_off_req_out(loff), .deep_failsafe_req_out(dfs),
    .prereg_lowside_drive_out(lsd), .prereg_highside_drive_out(hsd), .spread_enable_out(sen),
    .spread_range_select_out(srng), .clock_out_mux_select_out(mux), .clock_tune_out(tune),
    .external_ref_select_request_out(pulse), .ext_ref_divided_out(rdiv), .clock_output_out(cout)
  );
  always #25 clk_in = ~clk_in;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] rnd();
    seed = lfsr(seed);
    return seed[15:0];
  endfunction
  // expected read data: the masked stored value of a control register, or the live status bits a flag word shows on top of its stored ones
  function automatic logic [15:0] exp_rd(input logic [2:0] s);
    if (s < 3'h4)
      return regs[s[1:0]] & WM[s[1:0]];
    if (s == 3'h4)
      return {8'h0, win, 7'h0};
    if (s == 3'h5)
      return {3'h0, on_st[2], 1'b0, on_st[1], on_st[0], 9'h0};
    return 16'h0;
  endfunction
  // clock pins toggle at random so the phase delay is visible bit by bit
  always @(posedge clk_in)
  begin
    cseed <= lfsr(cseed);
    rck <= cseed[2:0];
    ha <= {ha[14:0], rck[0]};
    hb <= {hb[14:0], rck[1]};
    hc <= {hc[14:0], rck[2]};
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [2:0] s, input logic [15:0] extra);
    u_pmc_host_model.read(s, rd);
    chk(rd, exp_rd(s) | extra);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_in);
    num_errors++;
    stop_test();
  end
  initial
  begin
    logic [2:0]  s, fs, ms;
    logic [15:0] d, b;
    logic        m, rp;
    int          nr, nd;
    regs = '{default: 16'h0};
    repeat (12) @(posedge clk_in);
    reset_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    #1 chk({7'h0, loff, dfs, sen, srng, pulse, lsd, hsd}, 16'h0);
    for (int k = 0; k < 8; k++)
      rdchk(3'(k), (k == 5) ? 16'h40f1 : 16'h0);
    $display("test reset done");
    u_pmc_host_model.clear(3'h4, 16'hffff);
    u_pmc_host_model.clear(3'h5, 16'hffff);
    // all-ones corners first, then random traffic with live inputs moving
    for (int k = 0; k < 48; k++)
    begin
      s = (k < 8) ? 3'(k) : 3'(rnd());
      d = (k < 8) ? 16'hffff : rnd();
      win <= d[0];
      on_st <= d[3:1];
      u_pmc_host_model.write(s, d, int'(d[9:8]));
      if (s < 3'h4)
        regs[s[1:0]] = d;
      #1 chk({11'h0, lsd, 1'b0, hsd}, regs[0] & 16'h001b);
      chk({srng, mux, 4'h0, pulse, 1'b0, sen, tune}, (regs[1] & 16'hf81f) | ((s == 3'h1) ? d & 16'h0040 : 16'h0));
      rdchk(s, 16'h0);
    end
    $display("test registers done");
    for (int p = 0; p < 8; p++)
    begin
      d = rnd();
      d[10:8] = 3'(p);
      d[5] = 1'b0;
      regs[1] = d;
      u_pmc_host_model.write(3'h1, d, 0);
      repeat (12) @(posedge clk_in);
      repeat (6)
      begin
        @(posedge clk_in);
        #1 chk({cout, rdiv}, {d[7] ? hb[2 + p] : ha[2 + p], hc[2]});
      end
    end
    // divide by six: one divided rise per six reference rises, phase unknown
    d = rnd();
    d[5] = 1'b1;
    regs[1] = d;
    u_pmc_host_model.write(3'h1, d, 0);
    repeat (12) @(posedge clk_in);
    #1 rp = rdiv;
    nr = 0;
    nd = 0;
    repeat (600)
    begin
      @(posedge clk_in);
      #1 nr += (hc[2] && !hc[3]) ? 1 : 0;
      nd += (rdiv && !rp) ? 1 : 0;
      rp = rdiv;
    end
    chk({15'h0, nd > 0 && nr <= 6 * nd + 6 && nr + 6 >= 6 * nd}, 16'h1);
    $display("test clock output done");
    for (int i = 0; i < 16; i++)
    begin
      fs = (i < 8) ? 3'h4 : 3'h5;
      ms = (i == 0 || i > 7) ? 3'h3 : 3'h2;
      d = rnd();
      regs[ms[1:0]] = d;
      u_pmc_host_model.write(ms, d, 0);
      m = d[MB[i]];
      b = 16'h1 << FB[i];
      @(posedge clk_in);
      ev[i] <= 1'b1;
      repeat (2) @(posedge clk_in);
      // clear lands while the event is still high: the set must win
      u_pmc_host_model.clear(fs, b);
      #1 chk({loff, dfs}, (i == 7) ? {1'b1, regs[0][9]} : 2'h0);
      @(posedge clk_in);
      ev[i] <= 1'b0;
      repeat (6) @(posedge clk_in);
      #1 chk({irq, summ}, {~m, i == 1 || i == 8 || i == 10 || i == 11});
      rdchk(fs, b);
      u_pmc_host_model.clear(fs, ~b);
      rdchk(fs, b);
      u_pmc_host_model.clear(fs, b);
      repeat (3) @(posedge clk_in);
      #1 chk({irq, summ}, 2'h0);
      rdchk(fs, 16'h0);
    end
    $display("test events done");
    // a write while the enable is low must be lost
    @(posedge clk_in);
    en <= 1'b0;
    u_pmc_host_model.write(3'h0, ~regs[0], 0);
    en <= 1'b1;
    rdchk(3'h0, 16'h0);
    $display("test enable done");
    d = rnd();
    regs[3] = d;
    u_pmc_host_model.write(3'h3, d, 0);
    comm <= 1'b1;
    repeat (3) @(posedge clk_in);
    #1 chk(irq, {15'h0, ~d[9]});
    comm <= 1'b0;
    repeat (3) @(posedge clk_in);
    #1 chk(irq, 1'b0);
    $display("test comm mask done");
    stop_test();
  end
endmodule
`default_nettype wire
